// *** sdw_top.sv ***
/*
  sdw_top: write-only three-wire serial front end of a 10-bit voltage DAC.
  turns frame sync, shift clock and data pins into sixteen-bit frames
  and drives the DAC code, the operating mode, the one-hot ladder tap
  and the analog power-down and termination enables; a frame cut short
  leaves every output as it was, and the 1k, 100k and hi-z enables are
  never on together.
  assumes: sync_n, sclk and din are pins sampled by mclk, which must run
  well above the link rate, so that every link level lasts several mclk
  cycles; the host keeps din steady around each falling sclk edge and
  holds sync_n high a few mclk cycles between frames; arst_n stands for
  the power-on reset and leaves the synchronisers low, so sync_n must be
  seen high before the first frame can start.
*/
`timescale 1ns/1ps
`default_nettype none
module sdw_top (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic din,
  output logic [sdw_pkg::CODE_BITS-1:0] dac_code,
  output logic [sdw_pkg::MODE_BITS-1:0] op_mode,
  output logic [sdw_pkg::TAP_COUNT-1:0] tap_sel,
  output logic analog_shutdown,
  output logic pull_1k_en,
  output logic pull_100k_en,
  output logic out_hiz,
  output logic update_pulse
);
  // whole block state, registered once per mclk
  typedef struct packed {
    sdw_pkg::sdw_state_t state;
    logic [sdw_pkg::FRAME_BITS-1:0] shift;
    logic [sdw_pkg::CNT_BITS-1:0] cnt;
    logic sync_d;
    logic sclk_d;
    logic [sdw_pkg::CODE_BITS-1:0] code;
    logic [sdw_pkg::MODE_BITS-1:0] mode;
    logic [sdw_pkg::TAP_COUNT-1:0] taps;
    logic shdn;
    logic p1k;
    logic p100k;
    logic hiz;
    logic upd;
  } sdw_top_t;

  sdw_top_t st_r;
  sdw_top_t st_nxt;
  logic sync_s;
  logic sclk_s;
  logic din_s;
  logic [sdw_pkg::FRAME_BITS-1:0] frame;
  localparam int N_PINS = 3;
  logic [N_PINS-1:0] pin_raw;
  logic [N_PINS-1:0] pin_s;
  logic sync_fall;
  logic sclk_fall;

  function automatic logic [sdw_pkg::TAP_COUNT-1:0] tap_decode(
    input logic [sdw_pkg::CODE_BITS-1:0] code);
    logic [sdw_pkg::TAP_COUNT-1:0] t;
    t = '0;
    t[code] = 1'b1;
    return t;
  endfunction

  // falling edge between two samples of a synchronised level
  function automatic logic fell(
    input logic prev,
    input logic cur);
    return prev && !cur;
  endfunction

  // every mode but normal powers the analog part down
  function automatic logic is_pd(
    input logic [sdw_pkg::MODE_BITS-1:0] mode);
    return mode != sdw_pkg::SDW_MODE_NORMAL;
  endfunction

  // termination enables {1k, 100k, hi-z} for a mode
  function automatic logic [2:0] term_decode(
    input logic [sdw_pkg::MODE_BITS-1:0] mode);
    logic [2:0] t;
    t = 3'h0;
    case (mode)
      sdw_pkg::SDW_MODE_PD_1K: begin
        t = 3'h4;
      end
      sdw_pkg::SDW_MODE_PD_100K: begin
        t = 3'h2;
      end
      sdw_pkg::SDW_MODE_PD_HIZ: begin
        t = 3'h1;
      end
      default: begin
        t = 3'h0;
      end
    endcase
    return t;
  endfunction

  assign pin_raw = {sync_n, sclk, din};

  // one filtered synchroniser per link pin
  for (genvar g = 0; g < N_PINS; g++) begin : g_pin
    sdw_sync3 u_sync (
      .clk(mclk),
      .arst_n(arst_n),
      .din(pin_raw[g]),
      .dout(pin_s[g])
    );
  end

  assign sync_s = pin_s[2];
  assign sclk_s = pin_s[1];
  assign din_s = pin_s[0];
  assign sync_fall = fell(st_r.sync_d, sync_s);
  assign sclk_fall = fell(st_r.sclk_d, sclk_s);

  // msb first, last shifted bit lands at bit 0
  assign frame = {st_r.shift[sdw_pkg::FRAME_BITS-2:0], din_s};

  always_comb begin
    st_nxt = st_r;
    // edge history follows the synchronised pins
    st_nxt.sync_d = sync_s;
    st_nxt.sclk_d = sclk_s;
    // update pulse lasts one cycle
    st_nxt.upd = 1'b0;
    case (st_r.state)
      sdw_pkg::SDW_ST_IDLE: begin
        // start only on sync falling edge
        if (sync_fall) begin
          st_nxt.state = sdw_pkg::SDW_ST_SHIFT;
          st_nxt.cnt = sdw_pkg::CNT_RESET;
          st_nxt.shift = sdw_pkg::SHIFT_RESET;
        end
      end
      sdw_pkg::SDW_ST_SHIFT: begin
        // sync rise wins over a shift edge in the same cycle
        if (sync_s) begin
          st_nxt.state = sdw_pkg::SDW_ST_IDLE;
          st_nxt.shift = sdw_pkg::SHIFT_RESET;
          st_nxt.cnt = sdw_pkg::CNT_RESET;
        end else if (sclk_fall) begin
          st_nxt.shift = frame;
          st_nxt.cnt = st_r.cnt + 5'h01;
          if (st_r.cnt == sdw_pkg::LAST_BIT_CNT) begin
            st_nxt.state = sdw_pkg::SDW_ST_DONE;
            st_nxt.upd = 1'b1;
            // top two bits ignored, mode follows
            st_nxt.mode = {frame[sdw_pkg::MODE_HI_POS],
                           frame[sdw_pkg::MODE_LO_POS]};
            // a power-down frame keeps the code
            if (!is_pd(st_nxt.mode)) begin
              st_nxt.code =
                frame[sdw_pkg::CODE_MSB_POS:sdw_pkg::CODE_LSB_POS];
            end
          end
        end
      end
      sdw_pkg::SDW_ST_DONE: begin
        // stay done until sync rises
        // further shift edges land here and change nothing
        if (sync_s) begin
          st_nxt.state = sdw_pkg::SDW_ST_IDLE;
          st_nxt.cnt = sdw_pkg::CNT_RESET;
        end
      end
      default: begin
        st_nxt.state = sdw_pkg::SDW_ST_IDLE;
      end
    endcase
    {st_nxt.p1k, st_nxt.p100k, st_nxt.hiz} = term_decode(st_nxt.mode);
    st_nxt.shdn = is_pd(st_nxt.mode);
    st_nxt.taps = tap_decode(st_nxt.code);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
      st_r.taps <= {{(sdw_pkg::TAP_COUNT-1){1'b0}}, 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dac_code = st_r.code;
  assign op_mode = st_r.mode;
  assign tap_sel = st_r.taps;
  assign analog_shutdown = st_r.shdn;
  assign pull_1k_en = st_r.p1k;
  assign pull_100k_en = st_r.p100k;
  assign out_hiz = st_r.hiz;
  assign update_pulse = st_r.upd;
endmodule
`default_nettype wire

// *** sdw_pkg.sv ***
/*
  sdw_pkg: constants and types for the serial DAC write control block.
  assumes: used by sdw_top, sdw_props and tb only, referenced by scoped name.
*/
package sdw_pkg;
  localparam int FRAME_BITS = 16;
  localparam int CODE_BITS = 10;
  localparam int MODE_BITS = 2;
  localparam int TAP_COUNT = 1024;
  localparam int CNT_BITS = 5;
  // bit positions within a completed frame, first bit shifted is bit 15
  localparam int MODE_HI_POS = 13;
  localparam int MODE_LO_POS = 12;
  localparam int CODE_MSB_POS = 11;
  localparam int CODE_LSB_POS = 2;
  localparam logic [CNT_BITS-1:0] LAST_BIT_CNT = 5'h0F;
  localparam logic [CNT_BITS-1:0] CNT_RESET = 5'h00;
  localparam logic [CODE_BITS-1:0] CODE_RESET = 10'h000;
  localparam logic [FRAME_BITS-1:0] SHIFT_RESET = 16'h0000;
  // bench link clock period, used for documentation of the sampling margin
  localparam int MCLK_PERIOD_PS = 5000;
  localparam int LINK_PERIOD_PS = 160000;
  localparam int SAMPLES_PER_LINK = LINK_PERIOD_PS / MCLK_PERIOD_PS;

  typedef enum logic [MODE_BITS-1:0] {
    SDW_MODE_NORMAL = 2'h0,
    SDW_MODE_PD_1K = 2'h1,
    SDW_MODE_PD_100K = 2'h2,
    SDW_MODE_PD_HIZ = 2'h3
  } sdw_mode_t;

  // gray along idle -> shifting -> done
  typedef enum logic [1:0] {
    SDW_ST_IDLE = 2'h0,
    SDW_ST_SHIFT = 2'h1,
    SDW_ST_DONE = 2'h3
  } sdw_state_t;
endpackage

// *** sdw_sync3.sv ***
/*
  sdw_sync3: three-stage synchroniser with agreement filter.
  assumes: din is asynchronous to clk; output changes only when the
  second and third stages agree.
*/
`timescale 1ns/1ps
`default_nettype none
module sdw_sync3 (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } sdw_sync_t;

  sdw_sync_t st_r;
  sdw_sync_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.q = st_r.s3;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.q;
endmodule
`default_nettype wire

// *** sdw_props.sv ***
/* sdw_props: output checks for sdw_top.
   assumes: bound to sdw_top, one clock, async low reset. */
`timescale 1ns/1ps
`default_nettype none
module sdw_props (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic sync_n,
  input wire logic [sdw_pkg::CODE_BITS-1:0] dac_code,
  input wire logic [sdw_pkg::MODE_BITS-1:0] op_mode,
  input wire logic [sdw_pkg::TAP_COUNT-1:0] tap_sel,
  input wire logic analog_shutdown,
  input wire logic pull_1k_en,
  input wire logic pull_100k_en,
  input wire logic out_hiz,
  input wire logic update_pulse
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  tap_at_code_a:
    assert property (tap_sel == (1024'h1 << dac_code)) else $error("tap");
  shut_by_mode_a:
    assert property (analog_shutdown == (op_mode != 2'h0)) else $error("shut");
  pull_decode_a:
    assert property ({pull_1k_en, pull_100k_en, out_hiz} == {op_mode == 2'h1,
      op_mode == 2'h2, op_mode == 2'h3}) else $error("term");
  term_excl_a:
    assert property ($onehot0({pull_1k_en, pull_100k_en, out_hiz}))
      else $error("term excl");
  pulse_single_a:
    assert property (update_pulse |=> !update_pulse) else $error("pulse");
  code_hold_a:
    assert property ($changed(dac_code) |-> update_pulse) else $error("code");
  code_keep_pd_a:
    assert property (update_pulse && op_mode != 2'h0 |-> $stable(dac_code))
      else $error("code in pd");
  mode_hold_a:
    assert property (!update_pulse |-> $stable(op_mode)) else $error("mode");
  idle_quiet_a:
    assert property (sync_n [*8] |-> !update_pulse) else $error("idle");
endmodule
`default_nettype wire

// *** sdw_host.sv ***
/* sdw_host: host end of the write link.
   assumes: clk is the bench clock; pins move at its rising edge. */
`timescale 1ns/1ps
`default_nettype none
module sdw_host (
  input wire logic clk,
  output logic sync_n,
  output logic sclk,
  output logic din
);
  initial begin
    sync_n = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic send(input logic [15:0] w, input int n, input bit stray);
    sync_n <= 1'b0;
    wt(8);
    for (int i = 0; i < n; i++) begin
      din <= w[4'(15 - i)];
      wt(16);
      sclk <= 1'b0;
      wt(16);
      sclk <= 1'b1;
    end
    wt(8);
    sync_n <= 1'b1;
    // data parked low, clock stopped high
    din <= 1'b0;
    wt(6);
    // stray clock while sync is high
    if (stray) sclk <= 1'b0;
    wt(6);
    sclk <= 1'b1;
    wt(6);
  endtask
endmodule
`default_nettype wire

// *** sdw_tb.sv ***
/* tb: random, aborted and reset write frames into sdw_top.
   assumes: sdw_host drives the link pins. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk, arst_n, sync_n, sclk, din;
  logic [sdw_pkg::CODE_BITS-1:0] dac_code;
  logic [sdw_pkg::MODE_BITS-1:0] op_mode;
  logic [sdw_pkg::TAP_COUNT-1:0] tap_sel;
  logic analog_shutdown, pull_1k_en, pull_100k_en, out_hiz, update_pulse;
  logic [15:0] w, e, outs;
  int n_errors, checks, u0;
  int n_upd = 0;
  assign outs = {dac_code, op_mode, analog_shutdown, pull_1k_en,
    pull_100k_en, out_hiz};
  sdw_host host (.clk(mclk), .sync_n, .sclk, .din);
  sdw_top dut (.mclk, .arst_n, .sync_n, .sclk, .din, .dac_code, .op_mode,
    .tap_sel, .analog_shutdown, .pull_1k_en, .pull_100k_en, .out_hiz,
    .update_pulse);
  // pulses seen on the update output
  always @(posedge mclk) begin
    if (update_pulse === 1'b1) n_upd <= n_upd + 1;
  end
  function automatic logic [15:0] expd(input logic [15:0] v,
    input logic [15:0] prev);
    logic [1:0] m;
    logic [9:0] c;
    m = v[13:12];
    c = (m == 2'h0) ? v[11:2] : prev[15:6];
    return {c, m, m != 2'h0, m == 2'h1, m == 2'h2, m == 2'h3};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: outputs %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_tap(input logic [sdw_pkg::TAP_COUNT-1:0] got,
    input logic [sdw_pkg::CODE_BITS-1:0] code);
    logic [sdw_pkg::TAP_COUNT-1:0] x;
    x = '0;
    x[code] = 1'b1;
    checks++;
    if (got !== x) begin
      n_errors++;
      $display("ERROR %0t: tap select wrong for code %h", $time, code);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    checks++;
    if (got != exp) begin
      n_errors++;
      $display("ERROR %0t: %0d update pulses, expected %0d", $time, got,
        exp);
    end
  endtask
  task automatic finish_test;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic rst;
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    e = 16'h0000;
    chk(outs, e);
    chk_tap(tap_sel, 10'h000);
  endtask
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    #200000;
    n_errors++;
    finish_test();
  end
  initial begin
    n_errors = 0;
    checks = 0;
    arst_n = 1'b0;
    void'($urandom(32'h7BA4));
    rst();
    for (int i = 0; i < 24; i++) begin
      w = 16'($urandom());
      w[13:12] = 2'(i);
      if (i == 0) w[11:2] = 10'h3FF;
      if (i == 4) w[11:2] = 10'h000;
      // second reset in mid-run, frames must start afresh
      if (i == 12) rst();
      u0 = n_upd;
      host.send(w, (i % 3 == 2) ? 1 + $urandom_range(14) : 16 + 2 * (i % 3),
        i % 4 == 3);
      if (i % 3 != 2) e = expd(w, e);
      chk(outs, e);
      chk_tap(tap_sel, e[15:6]);
      chk_cnt(n_upd - u0, (i % 3 != 2) ? 1 : 0);
    end
    rst();
    finish_test();
  end
endmodule
bind sdw_top sdw_props u_props (.mclk, .arst_n, .sync_n, .dac_code,
  .op_mode, .tap_sel, .analog_shutdown, .pull_1k_en, .pull_100k_en,
  .out_hiz, .update_pulse);
`default_nettype wire
